/* File: pkg/pbm_pkg.sv */
// constants and types for the port b address pin multiplexer
// Function
// - port b upper pins serve as port pins or address outputs a15..a13.
// - modes 4-6, enable field 1xxx drives a15 on pin 7, direction ignored.
// - modes 4-6, enable field 0111 or 1xxx drives a14 on pin 6.
// - modes 4-6, enable field 011x or 1xxx drives a13 on pin 5.
// - modes 4-6 non-address pins follow direction bit: 0 input, 1 output.
// - mode 7 ignores enable field; direction bit alone picks input or output.
package pbm_pkg;
    // =========================================
    // register map, byte addresses
    localparam logic [11:0] PBM_ADDR_CTRL = 12'h000;
    localparam logic [11:0] PBM_ADDR_DIR = 12'h004;
    localparam logic [11:0] PBM_ADDR_DATA = 12'h008;
    localparam logic [11:0] PBM_ADDR_PINS = 12'h00C;
    localparam logic [11:0] PBM_ADDR_FUNC = 12'h010;
    // =========================================
    // field layout and reset values
    localparam int PBM_AE_W = 4;
    localparam int PBM_NPIN = 3;
    localparam int PBM_MODE_W = 3;
    localparam logic [3:0] PBM_AE_RST = 4'h0;
    localparam logic [2:0] PBM_DIR_RST = 3'h0;
    localparam logic [2:0] PBM_DATA_RST = 3'h0;
    localparam logic [2:0] PBM_MODE_SC = 3'h7;
    localparam logic [2:0] PBM_MODE_EXP_LO = 3'h4;
    localparam logic [3:0] PBM_AE_A14 = 4'h7;
    localparam logic [2:0] PBM_AE_A13_HI = 3'h3;
    localparam logic [31:0] PBM_RD_ZERO = 32'h0000_0000;
    // =========================================
    // bit positions and widths used by the selection logic
    localparam int PBM_DATA_W = 32;
    localparam int PBM_AE_ALL_BIT = 3;
    localparam int PBM_AE_PAIR_MSB = 3;
    localparam int PBM_AE_PAIR_LSB = 1;
    localparam int PBM_ABUS_PIN_MSB = 15;
    localparam int PBM_ABUS_PIN_LSB = 13;
    localparam int PBM_PIN7 = 2;
    localparam int PBM_PIN6 = 1;
    localparam int PBM_PIN5 = 0;
endpackage : pbm_pkg

/* File: src/pbm_pin_sel.sv */
// per-pin output select between address line and port data
`timescale 1ns/10ps
module pbm_pin_sel
    import pbm_pkg::*;
(
    input wire logic addr_sel,
    input wire logic addr_bit,
    input wire logic dir_bit,
    input wire logic data_bit,
    output logic pin_out,
    output logic pin_oe_n
);
    // address function overrides the direction bit
    assign pin_out = addr_sel ? addr_bit : data_bit;
    assign pin_oe_n = ~(addr_sel | dir_bit);
endmodule : pbm_pin_sel

/* File: src/pbm_top.sv */
// port b upper-pin address multiplexer with apb register access
`timescale 1ns/10ps
module pbm_top
    import pbm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] op_mode,
    input wire logic [15:9] addr_bus,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_n
);

    // =========================================
    // declarations
    // software-visible state
    logic [PBM_AE_W-1:0] ae_r;
    logic [PBM_NPIN-1:0] dir_r;
    logic [PBM_NPIN-1:0] data_r;
    logic [PBM_DATA_W-1:0] prdata_r;

    // next values of the software-visible state
    logic [PBM_AE_W-1:0] ae_nxt;
    logic [PBM_NPIN-1:0] dir_nxt;
    logic [PBM_NPIN-1:0] data_nxt;
    logic [PBM_DATA_W-1:0] prdata_nxt;

    // synchroniser stages for the inputs from outside the clock domain
    logic [PBM_MODE_W-1:0] mode_s1_r;
    logic [PBM_MODE_W-1:0] mode_r;
    logic [PBM_NPIN-1:0] pin_s1_r;
    logic [PBM_NPIN-1:0] pin_r;

    // apb request decode
    logic access;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_dir;
    logic hit_data;
    logic hit_pins;
    logic hit_func;
    logic hit_any;
    logic wr_ctrl;
    logic wr_dir;
    logic wr_data;

    // read words, one per register
    logic [PBM_DATA_W-1:0] rd_ctrl;
    logic [PBM_DATA_W-1:0] rd_dir;
    logic [PBM_DATA_W-1:0] rd_data;
    logic [PBM_DATA_W-1:0] rd_pins;
    logic [PBM_DATA_W-1:0] rd_func;
    logic [PBM_DATA_W-1:0] rd_mux;

    // mode and address-enable decode
    logic mode_in_range;
    logic mode_is_sc;
    logic expanded;
    logic ae_all;
    logic ae_a14;
    logic ae_a13;
    logic [PBM_NPIN-1:0] addr_sel;
    logic [PBM_NPIN-1:0] addr_bits;

    // =========================================
    // apb request decode
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign hit_ctrl = (paddr == PBM_ADDR_CTRL);
    assign hit_dir = (paddr == PBM_ADDR_DIR);
    assign hit_data = (paddr == PBM_ADDR_DATA);
    assign hit_pins = (paddr == PBM_ADDR_PINS);
    assign hit_func = (paddr == PBM_ADDR_FUNC);
    assign hit_any = hit_ctrl | hit_dir | hit_data | hit_pins | hit_func;
    // read-only and unmapped addresses get no write strobe, so such writes are dropped
    assign wr_ctrl = wr & hit_ctrl;
    assign wr_dir = wr & hit_dir;
    assign wr_data = wr & hit_data;

    // =========================================
    // apb response
    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;
    assign prdata = prdata_r;

    // =========================================
    // read data
    // unused upper bits read as zero so software may compare whole words
    assign rd_ctrl = {{(PBM_DATA_W-PBM_AE_W){1'b0}}, ae_r};
    assign rd_dir = {{(PBM_DATA_W-PBM_NPIN){1'b0}}, dir_r};
    assign rd_data = {{(PBM_DATA_W-PBM_NPIN){1'b0}}, data_r};
    assign rd_pins = {{(PBM_DATA_W-PBM_NPIN){1'b0}}, pin_r};
    assign rd_func = {{(PBM_DATA_W-PBM_MODE_W-PBM_NPIN){1'b0}}, mode_r, addr_sel};
    assign rd_mux = hit_ctrl ? rd_ctrl :
                    hit_dir ? rd_dir :
                    hit_data ? rd_data :
                    hit_pins ? rd_pins :
                    hit_func ? rd_func :
                    PBM_RD_ZERO;

    // =========================================
    // next-state values
    assign ae_nxt = wr_ctrl ? pwdata[PBM_AE_W-1:0] : ae_r;
    assign dir_nxt = wr_dir ? pwdata[PBM_NPIN-1:0] : dir_r;
    assign data_nxt = wr_data ? pwdata[PBM_NPIN-1:0] : data_r;
    // prdata only moves on a read, so it stands until the next one
    assign prdata_nxt = rd ? rd_mux : prdata_r;

    // =========================================
    // software-visible registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_r <= PBM_AE_RST;
        end else begin
            ae_r <= ae_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= PBM_DIR_RST;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= PBM_DATA_RST;
        end else begin
            data_r <= data_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= PBM_RD_ZERO;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // =========================================
    // synchronisers
    // mode straps and pin levels come from outside: two stages each,
    // and only the second stage is read by any logic
    // mode resets to single-chip so no address output can glitch out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_s1_r <= PBM_MODE_SC;
        end else begin
            mode_s1_r <= op_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= PBM_MODE_SC;
        end else begin
            mode_r <= mode_s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= PBM_DATA_RST;
        end else begin
            pin_s1_r <= pin_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= PBM_DATA_RST;
        end else begin
            pin_r <= pin_s1_r;
        end
    end

    // =========================================
    // operating mode decode
    // modes below 4 are not expanded here; treated like single-chip
    assign mode_in_range = (mode_r >= PBM_MODE_EXP_LO);
    assign mode_is_sc = (mode_r == PBM_MODE_SC);
    assign expanded = mode_in_range & ~mode_is_sc;

    // =========================================
    // address-enable decode
    assign ae_all = ae_r[PBM_AE_ALL_BIT];
    assign ae_a14 = (ae_r == PBM_AE_A14);
    assign ae_a13 = (ae_r[PBM_AE_PAIR_MSB:PBM_AE_PAIR_LSB] == PBM_AE_A13_HI);

    // =========================================
    // function select per pin
    // the address function wins over the direction bit
    assign addr_sel[PBM_PIN7] = expanded & ae_all;
    assign addr_sel[PBM_PIN6] = expanded & (ae_all | ae_a14);
    assign addr_sel[PBM_PIN5] = expanded & (ae_all | ae_a13);
    assign addr_bits = addr_bus[PBM_ABUS_PIN_MSB:PBM_ABUS_PIN_LSB];

    // =========================================
    // per-pin drivers: pin 7, 6, 5 map to bits 2, 1, 0
    // outputs stay combinational so the address pins track the bus in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < PBM_NPIN; gi++) begin : g_pin
            pbm_pin_sel u_sel (
                .addr_sel(addr_sel[gi]),
                .addr_bit(addr_bits[gi]),
                .dir_bit(dir_r[gi]),
                .data_bit(data_r[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe_n(pin_oe_n[gi])
            );
        end
    endgenerate

endmodule : pbm_top

/* File: tb/pbm_ext.sv */
// outside world on the three pins: other drivers show only while the mux lets go
`timescale 1ns/10ps
module pbm_ext (input wire logic [2:0] pin_out, pin_oe_n, ext, output logic [2:0] pin_in);
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : pbm_ext

/* File: tb/pbm_top_props.sv */
// assertions for the port b address pin mux
`timescale 1ns/10ps
module pbm_props import pbm_pkg::*; (input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr, input wire logic [31:0] pwdata, prdata, input wire logic pready, pslverr,
    input wire logic [2:0] op_mode, input wire logic [15:9] addr_bus, input wire logic [2:0] pin_in, pin_out, pin_oe_n);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] ae_r;
    logic [2:0] dir_r, dat_r;
    wire wr = psel && penable && pwrite;
    // mirror of the writable fields, so pin relations can be checked from the ports alone
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {ae_r, dir_r, dat_r} <= '0;
        else if (wr && paddr == PBM_ADDR_CTRL) ae_r <= pwdata[3:0];
        else if (wr && paddr == PBM_ADDR_DIR) dir_r <= pwdata[2:0];
        else if (wr && paddr == PBM_ADDR_DATA) dat_r <= pwdata[2:0];
    // mode passes a two-stage synchroniser, so it must stand three edges
    sequence s_exp; (op_mode inside {[4:6]})[*3]; endsequence
    sequence s_sc; (!(op_mode inside {[4:6]}))[*3]; endsequence
    property p_a15; s_exp ##0 ae_r[3] |-> !pin_oe_n[2] && pin_out[2] == addr_bus[15]; endproperty
    a_a15: assert property (p_a15) else $error("pin7 address wrong");
    property p_a14; s_exp ##0 (ae_r[3] || ae_r == 4'h7) |-> !pin_oe_n[1] && pin_out[1] == addr_bus[14]; endproperty
    a_a14: assert property (p_a14) else $error("pin6 address wrong");
    property p_a13; s_exp ##0 (ae_r[3] || ae_r[3:1] == 3'h3) |-> !pin_oe_n[0] && pin_out[0] == addr_bus[13]; endproperty
    a_a13: assert property (p_a13) else $error("pin5 address wrong");
    property p_port; s_exp ##0 ae_r < 4'h6 |-> pin_oe_n == ~dir_r; endproperty
    a_port: assert property (p_port) else $error("port direction wrong");
    property p_sc; s_sc |-> pin_oe_n == ~dir_r; endproperty
    a_sc: assert property (p_sc) else $error("single chip direction wrong");
    property p_dat; s_sc |-> (pin_out & dir_r) == (dat_r & dir_r); endproperty
    a_dat: assert property (p_dat) else $error("port data wrong");
    property p_rd; psel && penable && !pwrite && paddr == PBM_ADDR_CTRL |=> prdata == {28'h000_0000, ae_r}; endproperty
    a_rd: assert property (p_rd) else $error("field readback wrong");
    property p_err; psel && penable && paddr > PBM_ADDR_FUNC |-> pslverr && pready; endproperty
    a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule : pbm_props
bind pbm_top pbm_props CHK (.*);

/* File: tb/pbm_top_tb.sv */
// self-checking bench for the port b address pin mux
`timescale 1ns/10ps
module pbm_top_tb import pbm_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [2:0] op_mode = 3'h7, pin_in, pin_out, pin_oe_n, ext = 3'h0, dir, dat, m;
    logic [3:0] ae;
    logic [5:0] e;
    logic [15:9] addr_bus = 7'h00;
    int errors = 0, n_checks = 0, seed = 32'h16eb_fd7c, k;
    always #25 pclk = ~pclk;
    pbm_top DUT (.*);
    pbm_ext EXT (.*);
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, x);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin errors++; summarize(); end
        err = pslverr;
        {psel, penable} <= 2'b00;
        #1 rd = prdata;
    endtask : apb
    function automatic logic [2:0] exp_sel(logic [2:0] m, logic [3:0] ae);
        return (m inside {[4:6]}) ? {ae[3], ae[3] || ae == 4'h7, ae[3] || ae[3:1] == 3'h3} : 3'h0;
    endfunction : exp_sel
    function automatic logic [5:0] exp_pins(logic [2:0] m, logic [3:0] ae, logic [2:0] dir, dat, logic [15:9] ab);
        logic [2:0] s;
        s = exp_sel(m, ae);
        return {~(s | dir), (s & ab[15:13]) | (~s & dir & dat)};
    endfunction : exp_pins
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        #1 chk({29'h0, pin_oe_n}, 32'h0000_0007);
        apb(1, 12'h014, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001);
        apb(0, 12'h014, 0);
        chk(rd, PBM_RD_ZERO);
        chk({31'h0, err}, 32'h0000_0001);
        for (k = 0; k < 60; k++) begin
            // boundary enable codes 4..b in expanded modes first, then random
            m = (k < 8) ? 3'h4 + k[0] : 3'($random(seed));
            ae = (k < 8) ? 4'h4 + k[3:0] : 4'($random(seed));
            {dir, dat} = 6'($random(seed));
            @(posedge pclk);
            {op_mode, ext, addr_bus} <= {m, 3'($random(seed)), 7'($random(seed))};
            apb(1, PBM_ADDR_CTRL, {28'h000_0000, ae});
            apb(1, PBM_ADDR_DIR, {29'h0, dir});
            apb(1, PBM_ADDR_DATA, {29'h0, dat});
            repeat (3) @(posedge pclk);
            e = exp_pins(m, ae, dir, dat, addr_bus);
            #1 chk({26'h0, pin_oe_n, pin_out & ~pin_oe_n}, {26'h0, e});
            apb(0, PBM_ADDR_CTRL, 0);
            chk(rd, {28'h000_0000, ae});
            apb(0, PBM_ADDR_PINS, 0);
            chk(rd[2:0], e[2:0] | (ext & e[5:3]));
            chk({31'h0, err}, 32'h0000_0000);
            apb(0, PBM_ADDR_FUNC, 0);
            chk(rd, {26'h0, m, exp_sel(m, ae)});
            apb(0, PBM_ADDR_DIR, 0);
            chk(rd, {29'h0, dir});
            apb(0, PBM_ADDR_DATA, 0);
            chk(rd, {29'h0, dat});
        end
        summarize();
    end
endmodule : pbm_top_tb
